/* File: backplane_node_address_decode_bench.sv */
// Purpose: Self-checking bench joining the decoding node to a peer node
// Assumes: Node in slot 3, peer in slot 9, shared reset and clock
// Notes: Drivers queue expectations; negedge monitors pop them on pulses
`timescale 1ns/10ps
`default_nettype none

module backplane_node_address_decode_bench;
   localparam logic [3:0] NID = 4'h3;
   localparam logic [3:0] PID = 4'h9;
   localparam logic [29:0] ADDRS [10] = '{30'h2000_6004, 30'h2000_60fc, 30'h2000_6100,
      30'h2000_c000, 30'h2100_0000, 30'h213b_fffc, 30'h213c_0000, 30'h0000_6004,
      30'h1fff_fffc, 30'h3fff_fffc};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   bnad_pkg::bnad_cmd_e req_cmd = bnad_pkg::CMD_READ;
   logic [29:0] req_addr = 30'h0;
   logic [31:0] req_wdata = 32'h0;
   logic [31:0] tgt_rdata = 32'h0;
   logic intr_req = 1'b0;
   logic [15:0] intr_dest = 16'h0;
   logic rsp_valid, rsp_err, p_irq, n_irq, intr_done, id_valid, csr_stb, priv_stb, tgt_we;
   logic [31:0] rsp_rdata, tgt_wdata;
   logic [21:0] tgt_offset;
   logic [3:0] node_id, p_src, n_src;
   logic [31:0] seed = 32'h2af9_3c6e;
   int errors = 0;
   int n_tests = 0;
   logic [33:0] q_rsp[$];
   logic [55:0] q_tgt[$];
   logic [3:0] q_pirq[$];
   logic [3:0] q_nirq[$];

   always #20 clk = ~clk;
   bnad_bus_if bus ();
   bnad_node u_bnad_node (.clk(clk), .sys_rst(sys_rst), .slot_id(NID), .bus(bus),
      .node_id(node_id), .id_valid(id_valid), .tgt_csr_stb(csr_stb), .tgt_priv_stb(priv_stb),
      .tgt_we(tgt_we), .tgt_offset(tgt_offset), .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata),
      .intr_req(intr_req), .intr_dest(intr_dest), .intr_done(intr_done), .intr_rcv(n_irq),
      .intr_src(n_src));
   bnad_peer u_bnad_peer (.clk(clk), .sys_rst(sys_rst), .slot_id(PID), .bus(bus),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .intr_rcv(p_irq),
      .intr_src(p_src));
   bnad_chk #(.NODE_ID(NID)) u_bnad_chk (.clk(clk), .sys_rst(sys_rst), .node_d(bus.node_d),
      .node_d_oe(bus.node_d_oe), .peer_d_oe(bus.peer_d_oe), .node_ack(bus.node_ack),
      .node_ack_oe(bus.node_ack_oe), .bus_d(bus.bus_d));

   // ********************
   // Helpers
   // ********************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input logic [55:0] got, input logic [55:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic give_up();
      errors++;
      $display("[FAIL] %0t wait ran out", $time);
      end_of_test();
   endtask
   task automatic peer_op(input bnad_pkg::bnad_cmd_e cmd, input logic [29:0] addr,
                          input logic [15:0] mask);
      logic [29:0] ns;
      logic [29:0] pv;
      logic hc, hp, rd;
      int n;
      seed = xs(seed);
      ns = bnad_pkg::NS_BASE + (30'(NID) << bnad_pkg::NS_SHIFT);
      pv = bnad_pkg::PV_BASE + (30'(NID) << bnad_pkg::PV_SHIFT);
      hc = addr[29:8] == ns[29:8];
      hp = addr >= pv && (addr - pv) < 30'(bnad_pkg::PV_SIZE);
      rd = cmd == bnad_pkg::CMD_READ;
      @(posedge clk);
      req_valid <= 1'b1;
      req_cmd <= cmd;
      req_addr <= addr;
      req_wdata <= (cmd == bnad_pkg::CMD_INTR) ? {seed[31:16], mask} : seed;
      tgt_rdata <= {seed[15:0], seed[31:16]};
      if (cmd == bnad_pkg::CMD_INTR) begin
         q_rsp.push_back(34'h0);
         if (mask[NID]) q_nirq.push_back(PID);
      end else begin
         // Undriven lines read zero when nobody answers
         q_rsp.push_back({rd, !(hc || hp), (rd && (hc || hp)) ? {seed[15:0], seed[31:16]} : 32'h0});
         if (hc || hp) q_tgt.push_back({hp, !rd, hp ? 22'(addr - pv) : {14'h0, addr[7:0]},
            rd ? 32'h0 : seed});
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n > 200) give_up();
      end while (rsp_valid !== 1'b1);
      // Drop the request or the peer repeats it
      @(posedge clk);
      req_valid <= 1'b0;
   endtask
   task automatic node_intr(input logic [15:0] mask);
      int n;
      @(posedge clk);
      intr_req <= 1'b1;
      intr_dest <= mask;
      if (mask[PID]) q_pirq.push_back(NID);
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n > 200) give_up();
      end while (intr_done !== 1'b1);
      @(posedge clk);
      intr_req <= 1'b0;
   endtask

   // ********************
   // Monitors: an empty queue reads unknown, so stray pulses mismatch
   // ********************
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         check(56'({rsp_err, q_rsp[0][33] ? rsp_rdata : 32'h0}), 56'(q_rsp[0][32:0]));
         void'(q_rsp.pop_front());
      end
      if (csr_stb === 1'b1 || priv_stb === 1'b1) begin
         check({priv_stb, tgt_we, tgt_offset, tgt_we ? tgt_wdata : 32'h0}, q_tgt[0]);
         void'(q_tgt.pop_front());
      end
      if (p_irq === 1'b1) begin
         check(56'(p_src), 56'(q_pirq.pop_front()));
      end
      if (n_irq === 1'b1) begin
         check(56'(n_src), 56'(q_nirq.pop_front()));
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(negedge clk);
      check(56'({id_valid, node_id}), 56'({1'b1, NID}));
      $display("test identity done");
      for (int i = 0; i < 10; i++) begin
         peer_op(bnad_pkg::bnad_cmd_e'(2'(i % 2)), ADDRS[i], 16'h0);
      end
      $display("test address map done");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         peer_op(bnad_pkg::bnad_cmd_e'({1'b0, seed[30]}), seed[31] ?
            30'h2100_0000 + {10'h0, seed[19:2], 2'b00} : 30'h2000_6000 + {22'h0, seed[7:2], 2'b00},
            16'h0);
      end
      $display("test random access done");
      peer_op(bnad_pkg::CMD_INTR, 30'h0, 16'h0008);
      peer_op(bnad_pkg::CMD_INTR, 30'h0, 16'h8020);
      node_intr(16'h0200);
      fork
         node_intr(16'hfff7);
         peer_op(bnad_pkg::CMD_READ, 30'h2000_6010, 16'h0);
      join
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (60) @(negedge clk);
      check(56'(q_rsp.size() + q_tgt.size() + q_pirq.size() + q_nirq.size()), 56'h0);
      $display("test interrupts done");
      end_of_test();
   end
endmodule

`default_nettype wire

/* File: bnad_bus_if.sv */
// Purpose: Shared backplane lines between the decoding node and a peer node
// Assumes: Open-collector style lines, wired-OR of enabled drivers
// Notes: Undriven lines read as zero
`timescale 1ns/10ps
`default_nettype none

interface bnad_bus_if;
   logic [bnad_pkg::DATA_W-1:0] node_d;
   logic [bnad_pkg::DATA_W-1:0] node_d_oe;
   logic [bnad_pkg::DATA_W-1:0] peer_d;
   logic [bnad_pkg::DATA_W-1:0] peer_d_oe;
   logic node_ack;
   logic node_ack_oe;
   logic peer_ack;
   logic peer_ack_oe;
   logic [bnad_pkg::DATA_W-1:0] bus_d;
   logic bus_ack;

   assign bus_d = (node_d & node_d_oe) | (peer_d & peer_d_oe);
   assign bus_ack = (node_ack & node_ack_oe) | (peer_ack & peer_ack_oe);

   modport node (output node_d, node_d_oe, node_ack, node_ack_oe, input bus_d, bus_ack);
   modport peer (output peer_d, peer_d_oe, peer_ack, peer_ack_oe, input bus_d, bus_ack);
endinterface

`default_nettype wire

/* File: bnad_chk.sv */
// Purpose: Line-level checks between the decoding node and its peer
// Assumes: Local slot count tracks the node; both leave reset together
// Notes: A command slot is told apart by the slot ten cycles before it
`timescale 1ns/10ps
`default_nettype none

module bnad_chk #(
   parameter logic [3:0] NODE_ID = 4'h0
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [31:0] node_d,
   input wire logic [31:0] node_d_oe,
   input wire logic [31:0] peer_d_oe,
   input wire logic node_ack,
   input wire logic node_ack_oe,
   input wire logic [31:0] bus_d
);
   // ********************
   // Slot phase and own windows
   // ********************
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic [29:0] ns_base;
   logic [29:0] pv_base;
   logic [29:0] pv_off;
   logic own_hit;
   assign cnt_next = (cnt_reg == bnad_pkg::SLOT_LAST) ? bnad_pkg::SLOT_FIRST : cnt_reg + 3'h1;
   assign ns_base = bnad_pkg::NS_BASE + (30'(NODE_ID) << bnad_pkg::NS_SHIFT);
   assign pv_base = bnad_pkg::PV_BASE + (30'(NODE_ID) << bnad_pkg::PV_SHIFT);
   assign pv_off = bus_d[29:0] - pv_base;
   assign own_hit = (bus_d[29:8] == ns_base[29:8]) ||
                    (bus_d[29:0] >= pv_base && pv_off < 30'(bnad_pkg::PV_SIZE));
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= 3'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   // ********************
   // Properties
   // ********************
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Write data slots also drive every line, hence the look back
   sequence s_peer_rw_cmd;
      cnt_reg == 3'h4 && peer_d_oe == '1 && !bus_d[31] && $past(peer_d_oe, 10) != '1;
   endsequence
   sequence s_ack_slot;
      node_ack[*5];
   endsequence
   sequence s_quiet_slot;
      !node_ack[*5];
   endsequence
   a_own_ack: assert property (s_peer_rw_cmd ##0 own_hit |-> ##6 s_ack_slot)
      else $error("own command not acknowledged in data slot");
   a_foreign_quiet: assert property (s_peer_rw_cmd ##0 !own_hit |-> ##6 s_quiet_slot)
      else $error("foreign address acknowledged");
   a_read_drive: assert property (s_peer_rw_cmd ##0 own_hit && !bus_d[30] |-> ##6 (node_d_oe == '1)[*5])
      else $error("read data not driven for whole data slot");
   a_ack_whole_slot: assert property ($rose(node_ack) |-> node_ack_oe && cnt_reg == 3'h0 ##1 node_ack[*4] ##1 !node_ack)
      else $error("acknowledge not one aligned slot");
   a_ack_cause: assert property ($rose(node_ack) |-> $past(peer_d_oe, 6) == '1)
      else $error("acknowledge without command two slots before");
   a_lines_stand: assert property (cnt_reg != 3'h0 |-> $stable(node_d_oe) && $stable(node_d))
      else $error("node lines changed inside a slot");
   a_intr_form: assert property (node_d_oe == '1 && !node_ack &&
      node_d[31:30] == bnad_pkg::CMD_INTR &&
      $past(node_d_oe, 10) != '1 |-> node_d[29:0] == ns_base ##10 node_d_oe[15:0] == 16'hffff)
      else $error("interrupt command malformed");
   a_arb_own_bit: assert property (cnt_reg == 3'h4 && $onehot(node_d_oe) |->
      node_d_oe == (32'h1 << NODE_ID) || node_d_oe == (32'h1 << (16 + NODE_ID)))
      else $error("arbitration bit not own slot id");
endmodule

`default_nettype wire

/* File: bnad_node.sv */
// Purpose: Documented node: nodespace and private-space decode, bus timing
// Assumes: Same clock and reset as every other node; slot plug stable
// Notes: Answers reads and writes; sends and receives interrupt commands
`timescale 1ns/10ps
`default_nettype none

module bnad_node (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [bnad_pkg::ID_W-1:0] slot_id,
   bnad_bus_if.node bus,
   output logic [bnad_pkg::ID_W-1:0] node_id,
   output logic id_valid,
   output logic tgt_csr_stb,
   output logic tgt_priv_stb,
   output logic tgt_we,
   output logic [bnad_pkg::PV_SHIFT-1:0] tgt_offset,
   output logic [bnad_pkg::DATA_W-1:0] tgt_wdata,
   input wire logic [bnad_pkg::DATA_W-1:0] tgt_rdata,
   input wire logic intr_req,
   input wire logic [bnad_pkg::MASK_W-1:0] intr_dest,
   output logic intr_done,
   output logic intr_rcv,
   output logic [bnad_pkg::ID_W-1:0] intr_src
);

   // ************************************************************
   // State
   // ************************************************************
   logic [2:0] cnt_reg;
   bnad_pkg::bnad_slot_e slot_reg, slot_next;
   logic [31:0] lat_reg, d_reg, oe_reg, d_next, oe_next;
   logic ack_reg, ack_next, ack_in_reg;
   logic idv_reg, own_reg, boost_reg, sent_reg;
   logic [3:0] id_reg, last_reg, win_reg, src_reg;
   logic [1:0] cmd_reg;
   logic hitc_reg, hitp_reg;
   logic cstb_reg, pstb_reg, we_reg, done_reg, rcv_reg;
   logic [21:0] off_reg;
   logic [31:0] wdata_reg;

   wire slot_end = (cnt_reg == bnad_pkg::SLOT_LAST);
   wire slot_beg = (cnt_reg == bnad_pkg::SLOT_FIRST);

   // ************************************************************
   // Arbitration copy
   // ************************************************************
   wire [4:0] pick = bnad_pkg::bnad_arb_pick(lat_reg, last_reg);
   wire win_ok = pick[4];
   wire [3:0] win_id = pick[3:0];
   wire i_win = win_ok && idv_reg && (win_id == id_reg);
   // No new request while our own command is still in flight
   wire want = intr_req && idv_reg && !own_reg;
   wire [4:0] bank = boost_reg ? 5'(bnad_pkg::HI_LSB) : 5'(bnad_pkg::LO_LSB);
   wire [31:0] req_mask = 32'h0000_0001 << (bank + 5'(id_reg));
   wire to_arb = (slot_reg == bnad_pkg::SL_POST) ||
                 (slot_reg == bnad_pkg::SL_DECIDE && !win_ok);

   // ************************************************************
   // Address decode, from the command latched one slot earlier
   // ************************************************************
   wire [1:0] b_cmd = lat_reg[31:bnad_pkg::CMD_LSB];
   wire [29:0] b_addr = lat_reg[bnad_pkg::ADDR_W-1:0];
   wire is_io = b_addr[bnad_pkg::IO_BIT];
   wire [29:0] ns_base = bnad_pkg::NS_BASE + (30'(id_reg) << bnad_pkg::NS_SHIFT);
   wire [29:0] pv_base = bnad_pkg::PV_BASE + (30'(id_reg) << bnad_pkg::PV_SHIFT);
   wire in_ns = is_io && (b_addr[29:bnad_pkg::NS_SHIFT] ==
                          ns_base[29:bnad_pkg::NS_SHIFT]);
   wire hit_csr = in_ns &&
                  (b_addr[bnad_pkg::NS_SHIFT-1:bnad_pkg::CSR_SHIFT] == '0);
   wire hit_pv = is_io && (b_addr[29:bnad_pkg::PV_SHIFT] == pv_base[29:bnad_pkg::PV_SHIFT])
                 && (b_addr[bnad_pkg::PV_SHIFT-1:0] < bnad_pkg::PV_SIZE);
   wire is_rd = (b_cmd == bnad_pkg::CMD_READ);
   wire is_wr = (b_cmd == bnad_pkg::CMD_WRITE);
   // Own commands never target ourselves; reserved command ignored
   wire tgt_ok = idv_reg && !own_reg && (is_rd || is_wr) &&
                 (slot_reg == bnad_pkg::SL_DECODE);
   wire t_csr = tgt_ok && hit_csr;
   wire t_pv = tgt_ok && hit_pv;
   wire [21:0] t_off = t_csr ? 22'(b_addr[bnad_pkg::CSR_SHIFT-1:0])
                             : b_addr[bnad_pkg::PV_SHIFT-1:0];

   // ************************************************************
   // Slot sequence and line drive
   // ************************************************************
   always_comb begin
      slot_next = slot_reg;
      unique case (slot_reg)
         bnad_pkg::SL_ARB: slot_next = bnad_pkg::SL_DECIDE;
         bnad_pkg::SL_DECIDE: slot_next = win_ok ? bnad_pkg::SL_CMD : bnad_pkg::SL_ARB;
         bnad_pkg::SL_CMD: slot_next = bnad_pkg::SL_DECODE;
         bnad_pkg::SL_DECODE: slot_next = bnad_pkg::SL_DATA;
         bnad_pkg::SL_DATA: slot_next = bnad_pkg::SL_POST;
         bnad_pkg::SL_POST: slot_next = bnad_pkg::SL_ARB;
      endcase
   end

   // Values loaded at slot end appear at the next slot's leading edge
   always_comb begin
      d_next = '0;
      oe_next = '0;
      ack_next = 1'b0;
      if (to_arb && want) begin
         d_next = req_mask;
         oe_next = req_mask;
      end else if (slot_reg == bnad_pkg::SL_DECIDE && i_win) begin
         d_next = {bnad_pkg::CMD_INTR, ns_base};
         oe_next = '1;
      end else if (slot_reg == bnad_pkg::SL_DECODE && own_reg) begin
         d_next = 32'(intr_dest);
         oe_next = '1;
      end else if ((t_csr || t_pv) && is_rd) begin
         d_next = tgt_rdata;
         oe_next = '1;
         ack_next = 1'b1;
      end else if (t_csr || t_pv) begin
         ack_next = 1'b1;
      end
   end

   // ************************************************************
   // Clocked logic
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= bnad_pkg::SLOT_FIRST;
         id_reg <= '0;
         idv_reg <= 1'b0;
      end else begin
         cnt_reg <= slot_end ? bnad_pkg::SLOT_FIRST : cnt_reg + 3'h1;
         idv_reg <= 1'b1;
         // Plug caught once, on the first edge after reset release
         if (!idv_reg) id_reg <= slot_id;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slot_reg <= bnad_pkg::SL_ARB;
         lat_reg <= '0;
         ack_in_reg <= 1'b0;
         d_reg <= '0;
         oe_reg <= '0;
         ack_reg <= 1'b0;
      end else if (slot_end) begin
         lat_reg <= bus.bus_d;
         ack_in_reg <= bus.bus_ack;
         slot_reg <= slot_next;
         d_reg <= d_next;
         oe_reg <= oe_next;
         ack_reg <= ack_next;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_reg <= '0;
         win_reg <= '0;
         own_reg <= 1'b0;
         boost_reg <= 1'b0;
         sent_reg <= 1'b0;
         cmd_reg <= '0;
         hitc_reg <= 1'b0;
         hitp_reg <= 1'b0;
      end else if (slot_end) begin
         if (slot_reg == bnad_pkg::SL_ARB) sent_reg <= |oe_reg;
         if (slot_reg == bnad_pkg::SL_DECIDE && win_ok) begin
            last_reg <= win_id;
            win_reg <= win_id;
            own_reg <= i_win;
            // A loser moves to the high bank for its next try
            boost_reg <= sent_reg && !i_win;
         end
         if (slot_reg == bnad_pkg::SL_DECODE) begin
            cmd_reg <= b_cmd;
            hitc_reg <= t_csr;
            hitp_reg <= t_pv;
         end
         if (slot_reg == bnad_pkg::SL_POST) own_reg <= 1'b0;
      end
   end

   // Read strobes in the decode slot, write strobes after data latch
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cstb_reg <= 1'b0;
         pstb_reg <= 1'b0;
         we_reg <= 1'b0;
         off_reg <= '0;
         wdata_reg <= '0;
         done_reg <= 1'b0;
         rcv_reg <= 1'b0;
         src_reg <= '0;
      end else begin
         cstb_reg <= 1'b0;
         pstb_reg <= 1'b0;
         done_reg <= 1'b0;
         rcv_reg <= 1'b0;
         if (slot_beg && slot_reg == bnad_pkg::SL_DECODE) begin
            cstb_reg <= t_csr && is_rd;
            pstb_reg <= t_pv && is_rd;
            we_reg <= is_wr;
            off_reg <= t_off;
         end
         if (slot_beg && slot_reg == bnad_pkg::SL_POST) begin
            cstb_reg <= hitc_reg && (cmd_reg == bnad_pkg::CMD_WRITE);
            pstb_reg <= hitp_reg && (cmd_reg == bnad_pkg::CMD_WRITE);
            wdata_reg <= lat_reg;
            done_reg <= own_reg;
            rcv_reg <= (cmd_reg == bnad_pkg::CMD_INTR) && lat_reg[id_reg];
            src_reg <= win_reg;
         end
      end
   end

   assign bus.node_d = d_reg;
   assign bus.node_d_oe = oe_reg;
   assign bus.node_ack = ack_reg;
   assign bus.node_ack_oe = ack_reg;
   assign node_id = id_reg;
   assign id_valid = idv_reg;
   assign tgt_csr_stb = cstb_reg;
   assign tgt_priv_stb = pstb_reg;
   assign tgt_we = we_reg;
   assign tgt_offset = off_reg;
   assign tgt_wdata = wdata_reg;
   assign intr_done = done_reg;
   assign intr_rcv = rcv_reg;
   assign intr_src = src_reg;

endmodule

`default_nettype wire

/* File: bnad_peer.sv */
// Purpose: Far-side master node: reads, writes and interrupt commands
// Assumes: Same clock and reset as every other node
// Notes: Carries its own copy of the arbitration and slot sequencing
`timescale 1ns/10ps
`default_nettype none

module bnad_peer (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [bnad_pkg::ID_W-1:0] slot_id,
   bnad_bus_if.peer bus,
   input wire logic req_valid,
   input wire bnad_pkg::bnad_cmd_e req_cmd,
   input wire logic [bnad_pkg::ADDR_W-1:0] req_addr,
   input wire logic [bnad_pkg::DATA_W-1:0] req_wdata,
   output logic rsp_valid,
   output logic [bnad_pkg::DATA_W-1:0] rsp_rdata,
   output logic rsp_err,
   output logic intr_rcv,
   output logic [bnad_pkg::ID_W-1:0] intr_src
);

   // ************************************************************
   // State
   // ************************************************************
   logic [2:0] cnt_reg;
   bnad_pkg::bnad_slot_e slot_reg, slot_next;
   logic [31:0] lat_reg, d_reg, oe_reg, d_next, oe_next;
   logic ack_in_reg, idv_reg, own_reg, boost_reg, sent_reg;
   logic [3:0] id_reg, last_reg, win_reg, src_reg;
   logic [1:0] cmd_reg;
   logic rsp_reg, err_reg, rcv_reg;
   logic [31:0] rdata_reg;

   wire slot_end = (cnt_reg == bnad_pkg::SLOT_LAST);
   wire slot_beg = (cnt_reg == bnad_pkg::SLOT_FIRST);
   wire [4:0] pick = bnad_pkg::bnad_arb_pick(lat_reg, last_reg);
   wire win_ok = pick[4];
   wire [3:0] win_id = pick[3:0];
   wire i_win = win_ok && idv_reg && (win_id == id_reg);
   wire want = req_valid && idv_reg && !own_reg;
   wire [4:0] bank = boost_reg ? 5'(bnad_pkg::HI_LSB) : 5'(bnad_pkg::LO_LSB);
   wire [31:0] req_mask = 32'h0000_0001 << (bank + 5'(id_reg));
   wire to_arb = (slot_reg == bnad_pkg::SL_POST) ||
                 (slot_reg == bnad_pkg::SL_DECIDE && !win_ok);

   // ************************************************************
   // Slot sequence and line drive
   // ************************************************************
   always_comb begin
      slot_next = slot_reg;
      unique case (slot_reg)
         bnad_pkg::SL_ARB: slot_next = bnad_pkg::SL_DECIDE;
         bnad_pkg::SL_DECIDE: slot_next = win_ok ? bnad_pkg::SL_CMD : bnad_pkg::SL_ARB;
         bnad_pkg::SL_CMD: slot_next = bnad_pkg::SL_DECODE;
         bnad_pkg::SL_DECODE: slot_next = bnad_pkg::SL_DATA;
         bnad_pkg::SL_DATA: slot_next = bnad_pkg::SL_POST;
         bnad_pkg::SL_POST: slot_next = bnad_pkg::SL_ARB;
      endcase
   end

   always_comb begin
      d_next = '0;
      oe_next = '0;
      if (to_arb && want) begin
         d_next = req_mask;
         oe_next = req_mask;
      end else if (slot_reg == bnad_pkg::SL_DECIDE && i_win) begin
         d_next = {req_cmd, req_addr};
         oe_next = '1;
      end else if (slot_reg == bnad_pkg::SL_DECODE && own_reg) begin
         if (req_cmd == bnad_pkg::CMD_WRITE) begin
            d_next = req_wdata;
            oe_next = '1;
         end else if (req_cmd == bnad_pkg::CMD_INTR) begin
            d_next = 32'(req_wdata[bnad_pkg::MASK_W-1:0]);
            oe_next = '1;
         end
      end
   end

   // ************************************************************
   // Clocked logic
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= bnad_pkg::SLOT_FIRST;
         id_reg <= '0;
         idv_reg <= 1'b0;
      end else begin
         cnt_reg <= slot_end ? bnad_pkg::SLOT_FIRST : cnt_reg + 3'h1;
         idv_reg <= 1'b1;
         if (!idv_reg) id_reg <= slot_id;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slot_reg <= bnad_pkg::SL_ARB;
         lat_reg <= '0;
         ack_in_reg <= 1'b0;
         d_reg <= '0;
         oe_reg <= '0;
      end else if (slot_end) begin
         lat_reg <= bus.bus_d;
         ack_in_reg <= bus.bus_ack;
         slot_reg <= slot_next;
         d_reg <= d_next;
         oe_reg <= oe_next;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_reg <= '0;
         win_reg <= '0;
         own_reg <= 1'b0;
         boost_reg <= 1'b0;
         sent_reg <= 1'b0;
         cmd_reg <= '0;
      end else if (slot_end) begin
         if (slot_reg == bnad_pkg::SL_ARB) sent_reg <= |oe_reg;
         if (slot_reg == bnad_pkg::SL_DECIDE && win_ok) begin
            last_reg <= win_id;
            win_reg <= win_id;
            own_reg <= i_win;
            boost_reg <= sent_reg && !i_win;
         end
         if (slot_reg == bnad_pkg::SL_DECODE) cmd_reg <= lat_reg[31:bnad_pkg::CMD_LSB];
         if (slot_reg == bnad_pkg::SL_POST) own_reg <= 1'b0;
      end
   end

   // Results used only in the slot after latching
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rsp_reg <= 1'b0;
         err_reg <= 1'b0;
         rdata_reg <= '0;
         rcv_reg <= 1'b0;
         src_reg <= '0;
      end else begin
         rsp_reg <= 1'b0;
         rcv_reg <= 1'b0;
         if (slot_beg && slot_reg == bnad_pkg::SL_POST) begin
            rsp_reg <= own_reg;
            rdata_reg <= lat_reg;
            err_reg <= (req_cmd != bnad_pkg::CMD_INTR) && !ack_in_reg;
            rcv_reg <= (cmd_reg == bnad_pkg::CMD_INTR) && lat_reg[id_reg];
            src_reg <= win_reg;
         end
      end
   end

   assign bus.peer_d = d_reg;
   assign bus.peer_d_oe = oe_reg;
   assign bus.peer_ack = 1'b0;
   assign bus.peer_ack_oe = 1'b0;
   assign rsp_valid = rsp_reg;
   assign rsp_rdata = rdata_reg;
   assign rsp_err = err_reg;
   assign intr_rcv = rcv_reg;
   assign intr_src = src_reg;

endmodule

`default_nettype wire

/* File: bnad_pkg.sv */
// Purpose: Shared constants, types and arbitration for the backplane node pair
// Assumes: One 25 MHz clock shared by every node; bus cycle built from clock slots
// Notes: Both ends compile against this package; nothing is imported
//
// Overview of operation
// - Physical addresses are thirty bits wide everywhere
// - Low half memory, high half I/O space
// - Answer own 8K nodespace only, never others; code answers its low 256 bytes and private region
// - Nodespace low 256 bytes reach interface chip
// - On-board devices decoded only in private region
// - Node id and priority come from slot
// - Drive at cycle start, latch at end
// - Act on latched data one cycle later
// - Requests, addresses, data share 32 lines
// - Every node arbitrates; dual round-robin in slot-id order
// - Interrupts are commands to one or many
`default_nettype none

package bnad_pkg;

   // ************************************************************
   // Widths and timing
   // ************************************************************
   localparam int ADDR_W = 30;
   localparam int DATA_W = 32;
   localparam int ID_W = 4;
   localparam int NODES = 16;
   localparam int MASK_W = 16;
   localparam int CLK_NS = 40;
   localparam int BUS_CYC_NS = 200;
   localparam int SLOT_CLKS = (BUS_CYC_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] SLOT_LAST = 3'(SLOT_CLKS - 1);
   localparam logic [2:0] SLOT_FIRST = 3'h0;

   // ************************************************************
   // Address map
   // ************************************************************
   localparam int CMD_LSB = 30;
   localparam int IO_BIT = 29;
   localparam int NS_SHIFT = 13;
   localparam int CSR_SHIFT = 8;
   localparam int PV_SHIFT = 22;
   localparam logic [ADDR_W-1:0] NS_BASE = 30'h2000_0000;
   localparam logic [ADDR_W-1:0] PV_BASE = 30'h2040_0000;
   localparam logic [PV_SHIFT-1:0] PV_SIZE = 22'h3c_0000;
   localparam int HI_LSB = 0;
   localparam int LO_LSB = 16;

   typedef enum logic [1:0] {
      CMD_READ = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_INTR = 2'h2,
      CMD_RSVD = 2'h3
   } bnad_cmd_e;

   typedef enum logic [2:0] {
      SL_ARB,
      SL_DECIDE,
      SL_CMD,
      SL_DECODE,
      SL_DATA,
      SL_POST
   } bnad_slot_e;

   // ************************************************************
   // Arbitration: high bank first, each bank round-robin after last
   // ************************************************************
   function automatic logic [4:0] bnad_arb_pick(input logic [DATA_W-1:0] req,
                                                 input logic [ID_W-1:0] last);
      logic [4:0] res;
      logic [ID_W-1:0] idx;
      res = 5'h00;
      // Descending scan so the nearest id after last wins
      for (int k = NODES; k >= 1; k--) begin
         idx = last + 4'(k);
         if (req[LO_LSB + int'(idx)]) res = {1'b1, idx};
      end
      for (int k = NODES; k >= 1; k--) begin
         idx = last + 4'(k);
         if (req[HI_LSB + int'(idx)]) res = {1'b1, idx};
      end
      return res;
   endfunction

endpackage

`default_nettype wire
